// ===== dbp_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Constants and types for the debug and boundary-scan port
// Assumes: One 20 MHz clock, test pins sampled as ordinary inputs
// Notes:   Shared by the synchroniser, the TAP controller and the top
//------------------------------------------------------------------------------

package dbp_pkg;

   //---------------------------------------------------------------------------
   // Sizes
   //---------------------------------------------------------------------------
   localparam int NUM_BP   = 4;
   localparam int NUM_WP   = 2;
   localparam int ADDR_W   = 32;
   localparam int BSR_LEN  = 8;
   localparam int IR_LEN   = 2;
   localparam int DR_LEN   = 32;
   localparam int SYNC_W   = 5;

   //---------------------------------------------------------------------------
   // Instruction codes
   //---------------------------------------------------------------------------
   localparam logic [IR_LEN-1:0] IR_EXTEST  = 2'h0;
   localparam logic [IR_LEN-1:0] IR_SAMPLE  = 2'h1;
   localparam logic [IR_LEN-1:0] IR_IDCODE  = 2'h2;
   localparam logic [IR_LEN-1:0] IR_BYPASS  = 2'h3;
   localparam logic [IR_LEN-1:0] IR_CAPTURE = 2'h1;
   localparam logic [IR_LEN-1:0] IR_RESET   = IR_IDCODE;

   // Arbitrary identification value
   localparam logic [DR_LEN-1:0] ID_CODE = 32'h0000_0001;

   //---------------------------------------------------------------------------
   // Reset values
   //---------------------------------------------------------------------------
   // Pins idle high through pull-ups
   localparam logic [SYNC_W-1:0] SYNC_RST   = 5'h1F;
   localparam logic [DR_LEN-1:0] DR_RST     = 32'h0000_0000;
   localparam logic [BSR_LEN-1:0] BSR_RST   = 8'h00;

   //---------------------------------------------------------------------------
   // TAP states
   //---------------------------------------------------------------------------
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
   } dbp_tap_t;

endpackage

// ===== dbp_sync.sv
//------------------------------------------------------------------------------
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes:   Output follows once stages two and three agree
//------------------------------------------------------------------------------
`timescale 1ns/10ps

module dbp_sync
   import dbp_pkg::*;
#(
   parameter int               W   = 1,
   parameter logic [W-1:0]     RST = '1
) (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           nrst,
   // Data
   input  wire logic [W-1:0]   din,
   output      logic [W-1:0]   dout
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= RST;
         stage2 <= RST;
         stage3 <= RST;
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Accept bits where stages agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dout <= RST;
      end else begin
         dout <= (stage2 & ~(stage2 ^ stage3)) | (dout & (stage2 ^ stage3));
      end
   end

endmodule // dbp_sync

// ===== dbp_tap.sv
//------------------------------------------------------------------------------
// Purpose: Test access port state machine
// Assumes: tckRise is a one-cycle enable at each rising test clock edge
// Notes:   Moves to Run-Test/Idle at each test clock rise while the reset pin is high; test reset and brownout force Test-Logic-Reset
//------------------------------------------------------------------------------
`timescale 1ns/10ps

module dbp_tap
   import dbp_pkg::*;
(
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  nrst,
   // Test controls
   input  wire logic  tckRise,
   input  wire logic  tms,
   input  wire logic  trstN,
   input  wire logic  brownout,
   input  wire logic  resetPinHigh,
   // State
   output dbp_tap_t   tapState
);

   dbp_tap_t next_tapState;

   //---------------------------------------------------------------------------
   // Next state
   //---------------------------------------------------------------------------
   always_comb begin
      case (tapState)
         TLR:     next_tapState = tms ? TLR : RTI;
         RTI:     next_tapState = tms ? SEL_DR : RTI;
         SEL_DR:  next_tapState = tms ? SEL_IR : CAP_DR;
         CAP_DR:  next_tapState = tms ? EX1_DR : SH_DR;
         SH_DR:   next_tapState = tms ? EX1_DR : SH_DR;
         EX1_DR:  next_tapState = tms ? UP_DR : PA_DR;
         PA_DR:   next_tapState = tms ? EX2_DR : PA_DR;
         EX2_DR:  next_tapState = tms ? UP_DR : SH_DR;
         UP_DR:   next_tapState = tms ? SEL_DR : RTI;
         SEL_IR:  next_tapState = tms ? TLR : CAP_IR;
         CAP_IR:  next_tapState = tms ? EX1_IR : SH_IR;
         SH_IR:   next_tapState = tms ? EX1_IR : SH_IR;
         EX1_IR:  next_tapState = tms ? UP_IR : PA_IR;
         PA_IR:   next_tapState = tms ? EX2_IR : PA_IR;
         EX2_IR:  next_tapState = tms ? UP_IR : SH_IR;
         UP_IR:   next_tapState = tms ? SEL_DR : RTI;
         default: next_tapState = TLR;
      endcase
   end

   //---------------------------------------------------------------------------
   // State register
   //---------------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tapState <= TLR;
      end else if (!trstN || brownout) begin
         tapState <= TLR;
      end else if (tckRise) begin
         if (resetPinHigh) begin
            tapState <= RTI;
         end else begin
            tapState <= next_tapState;
         end
      end
   end

endmodule // dbp_tap

// ===== dbp_port.sv
//------------------------------------------------------------------------------
// Purpose: Debug and boundary-scan port top
// Assumes: Test pins asynchronous; core-side signals on clk
// Notes:   JTAG reaches the boundary, identification and bypass registers only
//------------------------------------------------------------------------------
`timescale 1ns/10ps

module dbp_port
   import dbp_pkg::*;
(
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       nrst,
   // External pins
   input  wire logic                       resetPinN,
   input  wire logic                       tckPin,
   input  wire logic                       tmsPin,
   input  wire logic                       tdiPin,
   input  wire logic                       trstPinN,
   output      logic                       tdoOut,
   output      logic                       tdoOe,
   // System status
   input  wire logic                       brownout,
   input  wire logic                       debugSession,
   input  wire logic                       cpuHalted,
   // Mode outputs
   output      logic                       jtagMode,
   output      logic                       swdEnable,
   output      logic                       systickStop,
   // Boundary cells
   input  wire logic [BSR_LEN-1:0]         bsrPinIn,
   output      logic [BSR_LEN-1:0]         bsrPinOut,
   output      logic                       bsrDrive,
   // Breakpoint and watchpoint setup
   input  wire logic [NUM_BP-1:0]          bpEnable,
   input  wire logic [NUM_BP*ADDR_W-1:0]   bpAddr,
   input  wire logic [NUM_WP-1:0]          wpEnable,
   input  wire logic [NUM_WP-1:0]          wpHaltEn,
   input  wire logic [NUM_WP*ADDR_W-1:0]   wpAddr,
   // Core bus observation
   input  wire logic                       fetchValid,
   input  wire logic [ADDR_W-1:0]          fetchAddr,
   input  wire logic                       dataValid,
   input  wire logic [ADDR_W-1:0]          dataAddr,
   // Debug events
   output      logic [NUM_BP-1:0]          bpHit,
   output      logic [NUM_WP-1:0]          wpTrigger,
   output      logic                       haltReq
);

   //---------------------------------------------------------------------------
   // Address compare
   //---------------------------------------------------------------------------
   function automatic logic addrMatch(
      input logic              en,
      input logic              valid,
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] ref_addr
   );
      addrMatch = en && valid && (addr[ADDR_W-1:1] == ref_addr[ADDR_W-1:1]);
   endfunction

   //---------------------------------------------------------------------------
   // Declarations
   //---------------------------------------------------------------------------
   logic [SYNC_W-1:0]  pinRaw;
   logic [SYNC_W-1:0]  pinSync;
   logic               resetHigh;
   logic               tck;
   logic               tms;
   logic               tdi;
   logic               trstN;
   logic               tckPrev;
   logic               tckRise;
   logic               tckFall;
   logic               swdLock;
   dbp_tap_t           tapState;
   logic [IR_LEN-1:0]  irShift;
   logic [IR_LEN-1:0]  irActive;
   logic [DR_LEN-1:0]  drShift;
   logic               bsrSel;
   logic [NUM_BP-1:0]  next_bpHit;
   logic [NUM_WP-1:0]  next_wpHit;

   //---------------------------------------------------------------------------
   // Pin synchronisers
   //---------------------------------------------------------------------------
   assign pinRaw = {resetPinN, tckPin, tmsPin, tdiPin, trstPinN};

   dbp_sync #(
      .W   (SYNC_W),
      .RST (SYNC_RST)
   ) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .din  (pinRaw),
      .dout (pinSync)
   );

   assign resetHigh = pinSync[4];
   assign tck       = pinSync[3];
   assign tms       = pinSync[2];
   assign tdi       = pinSync[1];
   assign trstN     = pinSync[0];

   //---------------------------------------------------------------------------
   // Test clock edges
   //---------------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tckPrev <= 1'b1;
      end else begin
         tckPrev <= tck;
      end
   end

   assign tckRise = tck && !tckPrev;
   assign tckFall = !tck && tckPrev;

   //---------------------------------------------------------------------------
   // Mode selection
   //---------------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         jtagMode <= 1'b0;
      end else begin
         jtagMode <= !resetHigh;
      end
   end

   // Serial wire debug held off after boundary scan until test reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         swdLock <= 1'b0;
      end else if (!trstN) begin
         swdLock <= 1'b0;
      end else if (!resetHigh) begin
         swdLock <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         swdEnable <= 1'b0;
      end else begin
         swdEnable <= resetHigh && !swdLock;
      end
   end

   //---------------------------------------------------------------------------
   // TAP controller
   //---------------------------------------------------------------------------
   dbp_tap u_tap (
      .clk          (clk),
      .nrst         (nrst),
      .tckRise      (tckRise),
      .tms          (tms),
      .trstN        (trstN),
      .brownout     (brownout),
      .resetPinHigh (resetHigh),
      .tapState     (tapState)
   );

   //---------------------------------------------------------------------------
   // Instruction register
   //---------------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irShift <= IR_CAPTURE;
      end else if (tckRise && jtagMode) begin
         case (tapState)
            CAP_IR:  irShift <= IR_CAPTURE;
            SH_IR:   irShift <= {tdi, irShift[IR_LEN-1:1]};
            default: irShift <= irShift;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irActive <= IR_RESET;
      end else if (tapState == TLR) begin
         irActive <= IR_RESET;
      end else if (tckRise && jtagMode && tapState == UP_IR) begin
         irActive <= irShift;
      end
   end

   assign bsrSel = (irActive == IR_EXTEST) || (irActive == IR_SAMPLE);

   //---------------------------------------------------------------------------
   // Data registers: boundary, identification, bypass
   //---------------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         drShift <= DR_RST;
      end else if (tckRise && jtagMode) begin
         case (tapState)
            CAP_DR: begin
               if (irActive == IR_IDCODE) begin
                  drShift <= ID_CODE;
               end else if (bsrSel) begin
                  drShift <= {{(DR_LEN-BSR_LEN){1'b0}}, bsrPinIn};
               end else begin
                  drShift <= DR_RST;
               end
            end
            SH_DR: begin
               if (irActive == IR_IDCODE) begin
                  drShift <= {tdi, drShift[DR_LEN-1:1]};
               end else if (bsrSel) begin
                  drShift <= {{(DR_LEN-BSR_LEN){1'b0}}, tdi,
                              drShift[BSR_LEN-1:1]};
               end else begin
                  drShift <= {{(DR_LEN-1){1'b0}}, tdi};
               end
            end
            default: drShift <= drShift;
         endcase
      end
   end

   // Boundary update latch
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bsrPinOut <= BSR_RST;
      end else if (tapState == TLR) begin
         bsrPinOut <= BSR_RST;
      end else if (tckRise && jtagMode && tapState == UP_DR && bsrSel) begin
         bsrPinOut <= drShift[BSR_LEN-1:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bsrDrive <= 1'b0;
      end else begin
         bsrDrive <= jtagMode && (irActive == IR_EXTEST) && (tapState != TLR);
      end
   end

   //---------------------------------------------------------------------------
   // Test data output, falling edge
   //---------------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tdoOut <= 1'b0;
         tdoOe  <= 1'b0;
      end else if (!jtagMode) begin
         tdoOe  <= 1'b0;
      end else if (tckFall) begin
         tdoOut <= (tapState == SH_IR) ? irShift[0] : drShift[0];
         tdoOe  <= (tapState == SH_IR) || (tapState == SH_DR);
      end
   end

   //---------------------------------------------------------------------------
   // Breakpoints and watchpoints
   //---------------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_BP; gi++) begin : g_bp
         assign next_bpHit[gi] = addrMatch(bpEnable[gi], fetchValid, fetchAddr,
                                           bpAddr[gi*ADDR_W +: ADDR_W]);
      end
      for (gi = 0; gi < NUM_WP; gi++) begin : g_wp
         assign next_wpHit[gi] = addrMatch(wpEnable[gi], dataValid, dataAddr,
                                           wpAddr[gi*ADDR_W +: ADDR_W]);
      end
   endgenerate

   // Debug events only through serial wire debug
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bpHit     <= '0;
         wpTrigger <= '0;
      end else begin
         bpHit     <= next_bpHit & {NUM_BP{swdEnable}};
         wpTrigger <= next_wpHit & {NUM_WP{swdEnable}};
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         haltReq <= 1'b0;
      end else begin
         haltReq <= swdEnable && ((|next_bpHit) || (|(next_wpHit & wpHaltEn)));
      end
   end

   //---------------------------------------------------------------------------
   // System tick halt
   //---------------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         systickStop <= 1'b0;
      end else begin
         systickStop <= debugSession && cpuHalted;
      end
   end

endmodule // dbp_port

// ===== dbp_port_asserts.sv
//------------------------------------------------------------------------------
// Purpose: Concurrent checks on the ports of the debug and boundary-scan port
// Assumes: One clk domain, pins pass a sync of four to five clk
// Notes:   Bound to dbp_port after the module
//------------------------------------------------------------------------------
`timescale 1ns/10ps

module dbp_port_asserts
   import dbp_pkg::*;
(
   // Clock and reset
   input wire logic                     clk,
   input wire logic                     nrst,
   // Pins and status
   input wire logic                     resetPinN,
   input wire logic                     tckPin,
   input wire logic                     tdoOut,
   input wire logic                     tdoOe,
   input wire logic                     brownout,
   input wire logic                     debugSession,
   input wire logic                     cpuHalted,
   // Mode outputs
   input wire logic                     jtagMode,
   input wire logic                     swdEnable,
   input wire logic                     systickStop,
   input wire logic                     bsrDrive,
   // Debug events
   input wire logic [NUM_BP-1:0]        bpEnable,
   input wire logic [NUM_BP*ADDR_W-1:0] bpAddr,
   input wire logic [NUM_WP-1:0]        wpEnable,
   input wire logic [NUM_WP-1:0]        wpHaltEn,
   input wire logic [NUM_WP*ADDR_W-1:0] wpAddr,
   input wire logic                     fetchValid,
   input wire logic [ADDR_W-1:0]        fetchAddr,
   input wire logic                     dataValid,
   input wire logic [ADDR_W-1:0]        dataAddr,
   input wire logic [NUM_BP-1:0]        bpHit,
   input wire logic [NUM_WP-1:0]        wpTrigger,
   input wire logic                     haltReq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   //---------------------------------------------------------------------------
   // Sequences
   //---------------------------------------------------------------------------
   sequence pin_low_held;
      !resetPinN [*7];
   endsequence
   sequence bp0_match;
      fetchValid && swdEnable && bpEnable[0] && fetchAddr[31:1] == bpAddr[31:1];
   endsequence
   sequence wp1_match;
      dataValid && swdEnable && wpEnable[1] && wpHaltEn[1] && dataAddr[31:1] == wpAddr[63:33];
   endsequence

   //---------------------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------------------
   chk_mode_follow: assert property ($fell(resetPinN) |-> ##[3:7] jtagMode)
      else $error("jtag mode late after reset pin low");
   chk_swd_off_low: assert property (pin_low_held |-> !swdEnable)
      else $error("swd enabled while reset pin low");
   chk_tdo_fall_edge: assert property ($changed(tdoOut) |->
      !$past(tckPin, 4) || !$past(tckPin, 5) || !$past(tckPin, 6))
      else $error("tdo changed away from test clock fall");
   chk_tdo_oe_mode: assert property ($rose(tdoOe) |-> jtagMode)
      else $error("tdo driven outside jtag mode");
   chk_bsr_brownout: assert property (brownout [*2] |=> !bsrDrive)
      else $error("boundary drive kept through brownout");
   chk_bp_hit: assert property (bp0_match |=> bpHit[0] && haltReq)
      else $error("breakpoint match gave no hit");
   chk_wp_halt: assert property (wp1_match |=> wpTrigger[1] && haltReq)
      else $error("watchpoint match gave no halt");
   chk_jtag_no_halt: assert property (!swdEnable |=> !haltReq && bpHit == '0)
      else $error("debug event without swd");
   chk_tick_stop: assert property (debugSession && cpuHalted |=> systickStop)
      else $error("tick timer runs while halted");
   chk_tick_run: assert property (!cpuHalted |=> !systickStop)
      else $error("tick timer stopped while running");
endmodule // dbp_port_asserts

bind dbp_port dbp_port_asserts chk_u (.clk, .nrst, .resetPinN, .tckPin, .tdoOut, .tdoOe,
   .brownout, .debugSession, .cpuHalted, .jtagMode, .swdEnable, .systickStop, .bsrDrive,
   .bpEnable, .bpAddr, .wpEnable, .wpHaltEn, .wpAddr, .fetchValid, .fetchAddr, .dataValid,
   .dataAddr, .bpHit, .wpTrigger, .haltReq);

// ===== dbp_tester.sv
//------------------------------------------------------------------------------
// Purpose: Boundary-scan tester model on the test pins
// Assumes: Test clock 400 ns period, only inside frames
// Notes:   Pulled-up pins idle high
//------------------------------------------------------------------------------
`timescale 1ns/10ps

module dbp_tester (
   // Test pins
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      trstN,
   output logic      resetN,
   // Returned data
   input wire logic  tdo,
   input wire logic  tdoOe
);
   // Idle pins, all driven high
   initial begin
      tck    = 1'h1;
      tms    = 1'h1;
      tdi    = 1'h1;
      trstN  = 1'h1;
      resetN = 1'h1;
   end

   // One test clock period of 400 ns
   task automatic tick(input logic m, input logic d, output logic o, output logic e);
      #13;
      tck = 1'h0;
      #100;
      tms = m;
      tdi = d;
      #100;
      tck = 1'h1;
      #187;
      o = tdoOe ? tdo : 1'hx;
      e = tdoOe;
   endtask

   // Power up high, wait, then reset low
   task automatic enter_scan();
      resetN = 1'h1;
      #1_000_000;
      resetN = 1'h0;
   endtask

   // Test reset pulse
   task automatic trst_pulse();
      trstN = 1'h0;
      #400;
      trstN = 1'h1;
      #400;
   endtask

   // Test reset, then release reset pin
   task automatic exit_scan();
      trstN = 1'h0;
      #400;
      resetN = 1'h1;
      #400;
      trstN = 1'h1;
   endtask
endmodule // dbp_tester

// ===== debug_and_boundary_scan_port_bench.sv
//------------------------------------------------------------------------------
// Purpose: Self-checking bench for the debug and boundary-scan port
// Assumes: 20 MHz clk, tester model on the test pins
// Notes:   Event rows first, scan flow after
//------------------------------------------------------------------------------
`timescale 1ns/10ps

module debug_and_boundary_scan_port_bench
   import dbp_pkg::*;
;
   typedef struct packed {
      logic [3:0] be; logic fv; logic [31:0] fa; logic dv; logic [31:0] da;
      logic ds; logic ch; logic [3:0] bp; logic [1:0] wp; logic hr; logic st;
   } dbp_row_t;
   logic clk, nrst, resetPinN, tckPin, tmsPin, tdiPin, trstPinN, tdoOut, tdoOe;
   logic brownout, debugSession, cpuHalted, jtagMode, swdEnable, systickStop, bsrDrive;
   logic fetchValid, dataValid, haltReq;
   logic [BSR_LEN-1:0] bsrPinIn, bsrPinOut;
   logic [NUM_BP-1:0] bpEnable, bpHit;
   logic [NUM_WP-1:0] wpEnable, wpHaltEn, wpTrigger;
   logic [NUM_BP*ADDR_W-1:0] bpAddr;
   logic [NUM_WP*ADDR_W-1:0] wpAddr;
   logic [ADDR_W-1:0] fetchAddr, dataAddr;
   logic [31:0] val;
   logic oe;
   int failures = 0;
   int numChecks = 0;
   dbp_row_t rows [6] = '{
      '{4'hF, 1'h1, 32'h100, 1'h0, 32'h0, 1'h0, 1'h0, 4'h1, 2'h0, 1'h1, 1'h0},
      '{4'hF, 1'h1, 32'h301, 1'h0, 32'h0, 1'h1, 1'h1, 4'h4, 2'h0, 1'h1, 1'h1},
      '{4'hF, 1'h1, 32'h400, 1'h1, 32'h1000, 1'h1, 1'h0, 4'h8, 2'h1, 1'h1, 1'h0},
      '{4'hF, 1'h1, 32'h502, 1'h1, 32'h2001, 1'h0, 1'h1, 4'h0, 2'h2, 1'h1, 1'h0},
      '{4'hF, 1'h0, 32'h100, 1'h1, 32'h1000, 1'h0, 1'h0, 4'h0, 2'h1, 1'h0, 1'h0},
      '{4'hE, 1'h1, 32'h100, 1'h0, 32'h0, 1'h1, 1'h1, 4'h0, 2'h0, 1'h0, 1'h1}};

   dbp_port dut_u (.clk, .nrst, .resetPinN, .tckPin, .tmsPin, .tdiPin, .trstPinN, .tdoOut,
      .tdoOe, .brownout, .debugSession, .cpuHalted, .jtagMode, .swdEnable, .systickStop,
      .bsrPinIn, .bsrPinOut, .bsrDrive, .bpEnable, .bpAddr, .wpEnable, .wpHaltEn, .wpAddr,
      .fetchValid, .fetchAddr, .dataValid, .dataAddr, .bpHit, .wpTrigger, .haltReq);
   dbp_tester tst_u (.tck(tckPin), .tms(tmsPin), .tdi(tdiPin), .trstN(trstPinN),
      .resetN(resetPinN), .tdo(tdoOut), .tdoOe(tdoOe));

   //---------------------------------------------------------------------------
   // Tasks
   //---------------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic run_row(input dbp_row_t r);
      @(posedge clk);
      {bpEnable, fetchValid, fetchAddr, dataValid, dataAddr} <= {r.be, r.fv, r.fa, r.dv, r.da};
      {debugSession, cpuHalted} <= {r.ds, r.ch};
      @(posedge clk);
      {fetchValid, dataValid} <= 2'h0;
      #1;
      check(bpHit, r.bp);
      check(wpTrigger, r.wp);
      check(haltReq, r.hr);
      check(systickStop, r.st);
   endtask
   task automatic tms_seq(input logic [3:0] s, input int n);
      logic o, e;
      for (int i = 0; i < n; i++)
         tst_u.tick(s[i], 1'h1, o, e);
   endtask
   task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout,
                        output logic oeAll);
      logic o, e;
      dout = 32'h0;
      oeAll = 1'h1;
      for (int i = 0; i < n; i++) begin
         tst_u.tick(i == n - 1, din[i], o, e);
         dout[i] = o;
         oeAll &= e;
      end
   endtask

   //---------------------------------------------------------------------------
   // Clock, watchdog and sequence
   //---------------------------------------------------------------------------
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   initial begin
      #3_000_000;
      failures++;
      end_sim();
   end
   initial begin
      nrst <= 1'h0;
      {brownout, debugSession, cpuHalted, fetchValid, dataValid} <= 5'h0;
      {fetchAddr, dataAddr} <= 64'h0;
      {bsrPinIn, bpEnable, wpEnable, wpHaltEn} <= {8'hA5, 4'hF, 2'h3, 2'h2};
      bpAddr <= {32'h400, 32'h300, 32'h200, 32'h100};
      wpAddr <= {32'h2000, 32'h1000};
      repeat (10) @(posedge clk);
      check(swdEnable, 1'h0);
      nrst <= 1'h1;
      repeat (8) @(posedge clk);
      #1 check(swdEnable, 1'h1);
      foreach (rows[i])
         run_row(rows[i]);
      tst_u.enter_scan();
      repeat (10) @(posedge clk);
      check(jtagMode, 1'h1);
      check(swdEnable, 1'h0);
      {fetchValid, fetchAddr} <= {1'h1, 32'h100};
      @(posedge clk);
      fetchValid <= 1'h0;
      #1 check(haltReq, 1'h0);
      tst_u.trst_pulse();
      tms_seq(4'h2, 4);
      shift(32, 32'h0, val, oe);
      check(val, ID_CODE);
      check(oe, 1'h1);
      tms_seq(4'h1, 2);
      tms_seq(4'h3, 4);
      shift(2, 32'h0, val, oe);
      check(val, 32'h1);
      tms_seq(4'h1, 2);
      tms_seq(4'h1, 3);
      shift(8, 32'h3C, val, oe);
      check(val, 32'hA5);
      tms_seq(4'h1, 2);
      repeat (4) @(posedge clk);
      check(bsrDrive, 1'h1);
      check(bsrPinOut, 8'h3C);
      brownout <= 1'h1;
      repeat (3) @(posedge clk);
      #1 check(bsrDrive, 1'h0);
      check(bsrPinOut, 8'h00);
      @(posedge clk) brownout <= 1'h0;
      tst_u.exit_scan();
      repeat (10) @(posedge clk);
      #1 check(swdEnable, 1'h1);
      check(jtagMode, 1'h0);
      tms_seq(4'h1, 1);
      tst_u.resetN = 1'h0;
      repeat (10) @(posedge clk);
      tms_seq(4'h1, 3);
      shift(1, 32'h0, val, oe);
      check(oe, 1'h1);
      end_sim();
   end
endmodule // debug_and_boundary_scan_port_bench
